// ==== asr_pkg.sv ====
// constants for the analog source select and trip reset block
package asr_pkg;
    // bus map, byte addresses
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_KEYPAD = 8'h04;
    localparam logic [7:0] OFF_STATUS = 8'h08;
    localparam logic [7:0] OFF_MASK = 8'h0C;
    localparam logic [7:0] OFF_FUNC_MAP = 8'h10;
    localparam logic [7:0] OFF_STATE = 8'h14;
    localparam logic [7:0] OFF_FREQ = 8'h18;
    localparam int ADDR_W = 8;

    // control register fields
    localparam int CTRL_SRC_LSB = 0;
    localparam int CTRL_SRC_W = 2;
    localparam logic [1:0] FREQ_SRC_ANALOG = 2'h1;
    localparam logic [1:0] CTRL_SRC_RST = 2'h1;
    localparam logic [15:0] KEYPAD_RST = 16'h0000;

    // terminal function map: one field per input terminal
    localparam int FUNC_W = 6;
    localparam logic [5:0] FUNC_ANALOG_SEL = 6'h10;
    localparam logic [5:0] FUNC_TRIP_RESET = 6'h12;
    // terminal 3 select, terminal 1 trip reset
    localparam logic [31:0] FUNC_MAP_RST = 32'h00010012;

    // status and mask bits
    localparam int EV_W = 3;
    localparam int EV_TRIP = 0;
    localparam int EV_RESET_DONE = 1;
    localparam int EV_REJECT = 2;
    localparam logic [2:0] MASK_RST = 3'h0;

    // state register fields
    localparam int ST_TRIP = 0;
    localparam int ST_ALARM = 1;
    localparam int ST_MOTOR = 2;
    localparam int ST_SEL = 3;
    localparam int ST_SUM = 4;
    localparam int ST_HELD = 5;
    localparam int ST_TERM_LSB = 8;

    // timing
    localparam int CLK_PERIOD_NS = 5;
    localparam int MS_NS = 1000000;
    localparam int CYC_PER_MS = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RST_MIN_MS = 12;
    localparam int ALARM_MAX_MS = 30;
endpackage

// ==== asr_pulse_qual.sv ====
// pulse width qualifier for the trip reset input, millisecond resolution
`timescale 1ns/1ps
module asr_pulse_qual #(
    parameter int CYC_PER_MS = asr_pkg::CYC_PER_MS,
    parameter int MIN_MS = asr_pkg::RST_MIN_MS
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic level,
    output logic held,
    output logic qual_pulse,
    output logic done_pulse,
    output logic reject_pulse
);
    typedef enum logic [1:0] {
        ASR_Q_IDLE = 2'b00,
        ASR_Q_TIMING = 2'b01,
        ASR_Q_HELD = 2'b10
    } asr_qstate_t;

    asr_qstate_t state_q;
    logic [31:0] cyc_q;
    logic [7:0] ms_q;
    logic ms_tick;
    logic counting;

    // divider starts on the first high sample, so a pulse of exactly the
    // minimum width still qualifies; any low sample restarts it from zero
    assign ms_tick = (cyc_q == 32'(CYC_PER_MS - 1));
    assign counting = level && (state_q == ASR_Q_IDLE || state_q == ASR_Q_TIMING);

    always_ff @(posedge clk) begin
        if (sys_rst || !counting || ms_tick) begin
            cyc_q <= 32'h00000000;
        end else begin
            cyc_q <= cyc_q + 32'h00000001;
        end
    end

    // sequencer: idle, timing the width, qualified and waiting for release
    always_ff @(posedge clk) begin
        qual_pulse <= 1'b0;
        done_pulse <= 1'b0;
        reject_pulse <= 1'b0;
        if (sys_rst) begin
            state_q <= ASR_Q_IDLE;
            ms_q <= 8'h00;
            held <= 1'b0;
        end else begin
            case (state_q)
                ASR_Q_IDLE: begin
                    ms_q <= 8'h00;
                    if (level) begin
                        state_q <= ASR_Q_TIMING;
                    end
                end
                ASR_Q_TIMING: begin
                    if (!level) begin
                        state_q <= ASR_Q_IDLE;
                        reject_pulse <= 1'b1; // short pulse ignored
                    end else if (ms_tick) begin
                        ms_q <= ms_q + 8'h01;
                        if (ms_q == 8'(MIN_MS - 1)) begin
                            state_q <= ASR_Q_HELD; // width reached
                            held <= 1'b1;
                            qual_pulse <= 1'b1;
                        end
                    end
                end
                ASR_Q_HELD: begin
                    if (!level) begin
                        state_q <= ASR_Q_IDLE;
                        held <= 1'b0;
                        done_pulse <= 1'b1; // on then off completes it
                    end
                end
                default: begin
                    state_q <= ASR_Q_IDLE;
                    held <= 1'b0;
                end
            endcase
        end
    end
endmodule

// ==== asr_top.sv ====
// analog source select and trip reset logic with an ahb-lite register slave
//
// Chosen here: the register addresses and register access over AHB-Lite.
`timescale 1ns/1ps
module asr_top #(
    parameter int CYC_PER_MS = asr_pkg::CYC_PER_MS,
    parameter int NUM_TERM = 5,
    parameter int AIN_W = 10,
    parameter int FREQ_W = 16
) (
    input wire logic clk,
    input wire logic sys_rst,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // input terminals and run command pins, asynchronous
    input wire logic [NUM_TERM-1:0] term_in,
    input wire logic run_cmd_in,
    // analog samples and fault event from same-clock logic
    input wire logic [AIN_W-1:0] voltage_analog_input,
    input wire logic [AIN_W-1:0] current_analog_input,
    input wire logic trip_fault,
    // results
    output logic [FREQ_W-1:0] freq_ref,
    output logic motor_en,
    output logic alarm_out,
    output logic powerup_reset,
    output logic irq
);
    // register state
    logic [1:0] freq_src_q;
    logic [15:0] keypad_q;
    logic [asr_pkg::EV_W-1:0] status_q;
    logic [asr_pkg::EV_W-1:0] mask_q;
    logic [31:0] func_map_q;

    // bus pipeline
    logic wr_pend_q;
    logic [asr_pkg::ADDR_W-1:0] wr_addr_q;
    logic addr_ok;
    logic [asr_pkg::ADDR_W-1:0] a_addr;
    logic [31:0] rd_data;

    // synchronisers
    logic [NUM_TERM-1:0] term_meta_q;
    logic [NUM_TERM-1:0] term_sync_q;
    logic run_meta_q;
    logic run_sync_q;

    // functions decoded from the terminal map
    logic [NUM_TERM-1:0] sel_map;
    logic [NUM_TERM-1:0] rst_map;
    logic sel_assigned;
    logic analog_source_select;
    logic trip_reset_input;

    // trip and reset
    logic trip_q;
    logic trip_d;
    logic rst_held;
    logic rst_qual;
    logic rst_done;
    logic rst_reject;
    logic [asr_pkg::EV_W-1:0] events;
    logic [asr_pkg::EV_W-1:0] w1c;
    logic [FREQ_W-1:0] freq_d;
    logic [AIN_W:0] ain_sum;

    // which terminals carry a given option code
    function automatic logic [NUM_TERM-1:0] asr_match(
        input logic [31:0] map,
        input logic [asr_pkg::FUNC_W-1:0] code
    );
        logic [NUM_TERM-1:0] m;
        m = '0;
        for (int i = 0; i < NUM_TERM; i++) begin
            m[i] = (map[i*asr_pkg::FUNC_W +: asr_pkg::FUNC_W] == code);
        end
        return m;
    endfunction

    // two flops on every pin before any logic looks at it
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            term_meta_q <= '0;
            term_sync_q <= '0;
            run_meta_q <= 1'b0;
            run_sync_q <= 1'b0;
        end else begin
            term_meta_q <= term_in;
            term_sync_q <= term_meta_q;
            run_meta_q <= run_cmd_in;
            run_sync_q <= run_meta_q;
        end
    end

    // function decode; a code on several terminals acts as an or
    assign sel_map = asr_match(func_map_q, asr_pkg::FUNC_ANALOG_SEL);
    assign rst_map = asr_match(func_map_q, asr_pkg::FUNC_TRIP_RESET);
    assign sel_assigned = |sel_map;
    assign analog_source_select = |(sel_map & term_sync_q);
    assign trip_reset_input = |(rst_map & term_sync_q);

    // width qualification of the trip reset input
    asr_pulse_qual #(
        .CYC_PER_MS(CYC_PER_MS),
        .MIN_MS(asr_pkg::RST_MIN_MS)
    ) u_qual (
        .clk(clk),
        .sys_rst(sys_rst),
        .level(trip_reset_input),
        .held(rst_held),
        .qual_pulse(rst_qual),
        .done_pulse(rst_done),
        .reject_pulse(rst_reject)
    );

    // frequency reference selection
    assign ain_sum = (AIN_W + 1)'(voltage_analog_input) + (AIN_W + 1)'(current_analog_input);
    always_comb begin
        freq_d = FREQ_W'(keypad_q);
        if (freq_src_q == asr_pkg::FREQ_SRC_ANALOG) begin // analog only when source is 01
            if (!sel_assigned) begin
                freq_d = FREQ_W'(ain_sum); // unassigned select sums both
            end else if (analog_source_select) begin
                freq_d = FREQ_W'(current_analog_input); // select on: current
            end else begin
                freq_d = FREQ_W'(voltage_analog_input); // select off: voltage
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            freq_ref <= '0;
        end else begin
            freq_ref <= freq_d;
        end
    end

    // trip state: a new fault wins over a clear in the same cycle
    always_comb begin
        trip_d = trip_q;
        if (trip_fault) begin
            trip_d = 1'b1;
        end else if (rst_qual) begin
            trip_d = 1'b0; // cleared at 12 ms, well inside 30 ms
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            trip_q <= 1'b0;
            alarm_out <= 1'b0;
        end else begin
            trip_q <= trip_d;
            alarm_out <= trip_d; // alarm follows trip state
        end
    end

    // motor drive; a still active run command restarts it after the reset
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            motor_en <= 1'b0;
        end else begin
            motor_en <= run_sync_q && !trip_d && !trip_reset_input;
        end
    end

    // power-up style reset for the rest of the device, one cycle at release
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            powerup_reset <= 1'b0;
        end else begin
            powerup_reset <= rst_done;
        end
    end

    // event sources for the sticky status bits
    always_comb begin
        events = '0;
        events[asr_pkg::EV_TRIP] = trip_fault && !trip_q;
        events[asr_pkg::EV_RESET_DONE] = rst_done;
        events[asr_pkg::EV_REJECT] = rst_reject;
    end

    // address phase is taken when the bus is ready and the transfer is real
    assign addr_ok = hsel && hready && htrans[1];
    assign a_addr = haddr[asr_pkg::ADDR_W-1:0];

    // write-one-to-clear strobe from a status write in its data phase
    always_comb begin
        w1c = '0;
        if (wr_pend_q && wr_addr_q == asr_pkg::OFF_STATUS) begin
            w1c = hwdata[asr_pkg::EV_W-1:0];
        end
    end

    // status: set beats clear so no event is lost
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            status_q <= '0;
        end else begin
            status_q <= (status_q & ~w1c) | events;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(((status_q & ~w1c) | events) & mask_q);
        end
    end

    // write capture; data arrives one cycle after the address
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= '0;
        end else if (hready) begin
            wr_pend_q <= addr_ok && hwrite;
            wr_addr_q <= a_addr;
        end
    end

    // writable registers; sub-word writes are not supported, full word assumed
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            freq_src_q <= asr_pkg::CTRL_SRC_RST;
            keypad_q <= asr_pkg::KEYPAD_RST;
            mask_q <= asr_pkg::MASK_RST;
            func_map_q <= asr_pkg::FUNC_MAP_RST;
        end else if (wr_pend_q) begin
            case (wr_addr_q)
                asr_pkg::OFF_CTRL: begin
                    freq_src_q <= hwdata[asr_pkg::CTRL_SRC_LSB +: asr_pkg::CTRL_SRC_W];
                end
                asr_pkg::OFF_KEYPAD: begin
                    keypad_q <= hwdata[15:0];
                end
                asr_pkg::OFF_MASK: begin
                    mask_q <= hwdata[asr_pkg::EV_W-1:0];
                end
                asr_pkg::OFF_FUNC_MAP: begin
                    func_map_q <= hwdata;
                end
                default: begin
                end
            endcase
        end
    end

    // read mux; unmapped offsets read zero
    always_comb begin
        rd_data = 32'h00000000;
        case (a_addr)
            asr_pkg::OFF_CTRL: begin
                rd_data[asr_pkg::CTRL_SRC_LSB +: asr_pkg::CTRL_SRC_W] = freq_src_q;
            end
            asr_pkg::OFF_KEYPAD: begin
                rd_data[15:0] = keypad_q;
            end
            asr_pkg::OFF_STATUS: begin
                rd_data[asr_pkg::EV_W-1:0] = status_q;
            end
            asr_pkg::OFF_MASK: begin
                rd_data[asr_pkg::EV_W-1:0] = mask_q;
            end
            asr_pkg::OFF_FUNC_MAP: begin
                rd_data = func_map_q;
            end
            asr_pkg::OFF_STATE: begin
                rd_data[asr_pkg::ST_TRIP] = trip_q;
                rd_data[asr_pkg::ST_ALARM] = alarm_out;
                rd_data[asr_pkg::ST_MOTOR] = motor_en;
                rd_data[asr_pkg::ST_SEL] = analog_source_select;
                rd_data[asr_pkg::ST_SUM] = !sel_assigned;
                rd_data[asr_pkg::ST_HELD] = rst_held;
                rd_data[asr_pkg::ST_TERM_LSB +: NUM_TERM] = term_sync_q;
            end
            asr_pkg::OFF_FREQ: begin
                rd_data = 32'(freq_ref);
            end
            default: begin
                rd_data = 32'h00000000;
            end
        endcase
    end

    // read data is latched at the address phase so it stands in the data phase;
    // the limitation is that it reflects state one cycle before the data phase
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            hrdata <= 32'h00000000;
        end else if (addr_ok && !hwrite) begin
            hrdata <= rd_data;
        end
    end

    // zero wait state slave, always okay
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

endmodule

// ==== asr_chk.sv ====
// assertion checker for the trip reset, alarm and motor pins
`timescale 1ns/1ps
module asr_chk #(
    parameter int CYC_PER_MS = 10,
    parameter int NUM_TERM = 5
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [NUM_TERM-1:0] term_in,
    input wire logic run_cmd_in,
    input wire logic trip_fault,
    input wire logic motor_en,
    input wire logic alarm_out,
    input wire logic powerup_reset
);
    // terminal 1 is kept on the reset function in every map the bench writes
    localparam int MIN_CYC = 12 * CYC_PER_MS;
    localparam int HOLD_CYC = MIN_CYC + 8;
    localparam int LEFT_CYC = 30 * CYC_PER_MS - HOLD_CYC;
    int hi_q;

    // length of the current high run, saturating so long holds stay cheap
    always_ff @(posedge clk) begin
        if (sys_rst || !term_in[0]) begin
            hi_q <= 0;
        end else if (hi_q <= HOLD_CYC) begin
            hi_q <= hi_q + 1;
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);

    a_motor_off_hold: assert property (term_in[0] [*5] |-> !motor_en)
        else $error("motor drive on while reset pin held");
    a_alarm_clear_bound: assert property (hi_q == HOLD_CYC |-> ##[0:LEFT_CYC] !alarm_out)
        else $error("alarm still on late after reset onset");
    a_short_no_reset: assert property (
        $fell(term_in[0]) && hi_q < MIN_CYC - 2 |-> !powerup_reset [*8])
        else $error("short pulse produced a reset");
    a_short_keeps_trip: assert property (
        $fell(term_in[0]) && hi_q < MIN_CYC - 2 && alarm_out |-> alarm_out [*8])
        else $error("short pulse cleared the alarm");
    a_long_gives_reset: assert property (
        $fell(term_in[0]) && hi_q > MIN_CYC + 4 |-> ##[1:6] powerup_reset)
        else $error("no reset after a full pulse");
    a_reset_pulse_one: assert property (powerup_reset |=> !powerup_reset)
        else $error("reset pulse longer than one cycle");
    a_motor_resume: assert property ($fell(term_in[0]) && hi_q > MIN_CYC + 4 && run_cmd_in
        && !trip_fault |-> ##[1:8] motor_en)
        else $error("motor did not resume with run on");
    a_alarm_from_fault: assert property ($rose(alarm_out)
        |-> $past(trip_fault) || $past(trip_fault, 2) || $past(trip_fault, 3))
        else $error("alarm rose without a fault");

    c_long_pulse: cover property ($fell(term_in[0]) && hi_q > MIN_CYC + 4);
    c_short_pulse: cover property ($fell(term_in[0]) && hi_q < MIN_CYC - 2);
    c_reset_seen: cover property (powerup_reset);
endmodule

bind asr_top asr_chk #(.CYC_PER_MS(CYC_PER_MS), .NUM_TERM(NUM_TERM)) i_asr_chk (
    .clk(clk), .sys_rst(sys_rst), .term_in(term_in), .run_cmd_in(run_cmd_in),
    .trip_fault(trip_fault), .motor_en(motor_en), .alarm_out(alarm_out),
    .powerup_reset(powerup_reset));

// ==== asr_term_model.sv ====
// model of the outside controller driving the input terminals
`timescale 1ns/1ps
module asr_term_model #(
    parameter int CYC_PER_MS = 10
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic sel_on,
    input wire logic run_on,
    input wire logic fire,
    input wire logic [7:0] width_ms,
    output logic [4:0] term_in,
    output logic run_cmd_in,
    output logic busy
);
    int left_q;
    logic busy_q;

    // reset pin held for the commanded width; two scenarios ask below 12 ms
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            busy_q <= 1'b0;
            left_q <= 0;
        end else if (fire && !busy_q) begin
            busy_q <= 1'b1;
            left_q <= int'(width_ms) * CYC_PER_MS - 1;
        end else if (busy_q && left_q == 0) begin
            busy_q <= 1'b0;
        end else if (busy_q) begin
            left_q <= left_q - 1;
        end
    end

    // terminal 1 reset, terminal 3 select, rest idle low
    assign term_in = {2'h0, sel_on, 1'b0, busy_q};
    assign run_cmd_in = run_on;
    assign busy = busy_q;
endmodule

// ==== asr_top_tb_top.sv ====
// self-checking bench for the analog select and trip reset block
`timescale 1ns/1ps
module asr_top_tb_top;
    localparam int CPM = 10;
    localparam logic [31:0] MSEL = 32'h00010012;
    typedef struct {
        logic [1:0] src;
        logic [31:0] map;
        logic sel;
        logic [9:0] v;
        logic [9:0] i;
        logic [15:0] exp;
    } asr_row_t;
    // frequency source rows: analog pick, keypad fallback, sum when unmapped
    asr_row_t rows [5] = '{'{2'h1, MSEL, 1'b1, 10'h123, 10'h2A5, 16'h02A5},
        '{2'h1, MSEL, 1'b0, 10'h123, 10'h2A5, 16'h0123},
        '{2'h0, MSEL, 1'b1, 10'h123, 10'h2A5, 16'hBEEF},
        '{2'h3, MSEL, 1'b0, 10'h123, 10'h2A5, 16'hBEEF},
        '{2'h1, 32'h00000012, 1'b1, 10'h3FF, 10'h3FF, 16'h07FE}};
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic [4:0] term_in;
    logic run_cmd_in;
    logic [9:0] vin = 10'h0;
    logic [9:0] cin = 10'h0;
    logic trip_fault = 1'b0;
    logic [15:0] freq_ref;
    logic motor_en;
    logic alarm_out;
    logic powerup_reset;
    logic irq;
    logic sel_on = 1'b0;
    logic run_on = 1'b0;
    logic fire = 1'b0;
    logic [7:0] width_ms = 8'h00;
    logic busy;
    logic mlo;
    int ac;
    int pu;
    int num_errors = 0;
    int samples_checked = 0;

    initial begin
        forever #2.5 clk = ~clk;
    end

    asr_top #(.CYC_PER_MS(CPM)) i_asr_top (.clk(clk), .sys_rst(sys_rst), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .term_in(term_in), .run_cmd_in(run_cmd_in), .voltage_analog_input(vin),
        .current_analog_input(cin), .trip_fault(trip_fault), .freq_ref(freq_ref),
        .motor_en(motor_en), .alarm_out(alarm_out), .powerup_reset(powerup_reset), .irq(irq));
    asr_term_model #(.CYC_PER_MS(CPM)) i_asr_term_model (.clk(clk), .sys_rst(sys_rst),
        .sel_on(sel_on), .run_on(run_on), .fire(fire), .width_ms(width_ms),
        .term_in(term_in), .run_cmd_in(run_cmd_in), .busy(busy));

    task automatic tally_and_finish;
        if (num_errors == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        chk_word({31'h0, got}, {31'h0, exp});
    endtask

    // the master never assumes a latency, so every phase waits on ready
    task automatic wait_rdy;
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (hreadyout !== 1'b1 && n < 64);
        if (n >= 64) begin
            num_errors++;
            tally_and_finish();
        end
    endtask

    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] q);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= wr;
        wait_rdy();
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= d;
        wait_rdy();
        q = hrdata;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        ahb(1'b1, a, d, q);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        logic [31:0] q;
        ahb(1'b0, a, 32'h0, q);
        chk_word(q & m, e);
        chk_bit(hresp, 1'b0);
    endtask

    // one pulse on the reset pin, watching alarm, reset pulse and motor meanwhile
    task automatic rs_pulse(input logic [7:0] ms);
        int tail;
        tail = 0;
        ac = -1;
        pu = 0;
        mlo = 1'b0;
        width_ms <= ms;
        fire <= 1'b1;
        @(posedge clk);
        fire <= 1'b0;
        for (int n = 0; n < 2000 && tail < 8; n++) begin
            @(posedge clk);
            ac = (ac < 0 && alarm_out !== 1'b1) ? n + 1 : ac;
            pu += (powerup_reset === 1'b1);
            // motor must be off from the fourth cycle of the pulse until release
            mlo |= (motor_en === 1'b1 && busy === 1'b1 && n >= 3);
            tail += (busy !== 1'b1);
        end
        if (tail < 8) begin
            num_errors++;
            tally_and_finish();
        end
    endtask

    initial begin
        repeat (12) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        wr(asr_pkg::OFF_KEYPAD, 32'h0000BEEF);
        foreach (rows[k]) begin
            wr(asr_pkg::OFF_CTRL, {30'h0, rows[k].src});
            wr(asr_pkg::OFF_FUNC_MAP, rows[k].map);
            sel_on <= rows[k].sel;
            vin <= rows[k].v;
            cin <= rows[k].i;
            repeat (8) @(posedge clk);
            chk_word({16'h0, freq_ref}, {16'h0, rows[k].exp});
        end
        // trip entry raises the alarm and the status bit
        wr(asr_pkg::OFF_MASK, 32'h00000007);
        run_on <= 1'b1;
        trip_fault <= 1'b1;
        @(posedge clk);
        trip_fault <= 1'b0;
        repeat (6) @(posedge clk);
        chk_bit(alarm_out, 1'b1);
        chk_bit(irq, 1'b1);
        rd_chk(asr_pkg::OFF_STATUS, 32'hFFFFFFFF, 32'h00000001);
        // short pulse: motor off meanwhile, but no reset executed
        rs_pulse(8'h05);
        chk_bit(mlo, 1'b0);
        chk_word(32'(pu), 32'h0);
        chk_bit(alarm_out, 1'b1);
        rd_chk(asr_pkg::OFF_STATUS, 32'hFFFFFFFF, 32'h00000005);
        wr(asr_pkg::OFF_STATUS, 32'h00000007);
        wr(asr_pkg::OFF_MASK, 32'h00000001);
        rd_chk(asr_pkg::OFF_STATUS, 32'hFFFFFFFF, 32'h0);
        chk_bit(irq, 1'b0);
        // full pulse with run left on: trip cleared in time, motor comes back
        rs_pulse(8'h0D);
        chk_bit(ac >= 0 && ac < 30 * CPM, 1'b1);
        chk_word(32'(pu), 32'h1);
        chk_bit(mlo, 1'b0);
        repeat (8) @(posedge clk);
        chk_bit(motor_en, 1'b1);
        rd_chk(asr_pkg::OFF_STATE, 32'h00000007, 32'h00000004);
        chk_bit(irq, 1'b0);
        rd_chk(asr_pkg::OFF_STATUS, 32'h00000007, 32'h00000002);
        wr(asr_pkg::OFF_MASK, 32'h00000002);
        repeat (2) @(posedge clk);
        chk_bit(irq, 1'b1);
        wr(asr_pkg::OFF_STATUS, 32'h00000002);
        repeat (2) @(posedge clk);
        chk_bit(irq, 1'b0);
        // short pulse with the motor running: forced off while held, then back
        rs_pulse(8'h03);
        chk_bit(mlo, 1'b0);
        chk_word(32'(pu), 32'h0);
        chk_bit(motor_en, 1'b1);
        rd_chk(8'h40, 32'hFFFFFFFF, 32'h0);
        // second reset in mid-run, then register reset values
        sys_rst <= 1'b1;
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        chk_bit(alarm_out | motor_en | irq | powerup_reset, 1'b0);
        rd_chk(asr_pkg::OFF_CTRL, 32'h00000003, {30'h0, asr_pkg::CTRL_SRC_RST});
        rd_chk(asr_pkg::OFF_KEYPAD, 32'h0000FFFF, 32'h0);
        rd_chk(asr_pkg::OFF_MASK, 32'h00000007, 32'h0);
        rd_chk(asr_pkg::OFF_FUNC_MAP, 32'hFFFFFFFF, asr_pkg::FUNC_MAP_RST);
        tally_and_finish();
    end
endmodule
